// ### rtl/swu_slave.sv
// receiver of single-wire uart datagrams with baud detection and register write port
// assumes line and address pins synchronous to clk_sys; read replies are not sent
`timescale 1ns/1ps
`include "swu_cfg.svh"
module swu_slave
  import swu_pkg::*;
#(
  parameter int CW        = 26,
  parameter int BW        = 20,
  parameter int BIT_INIT  = `SWU_BIT_MAX_CYC,
  parameter int BUF_DEPTH = `SWU_BUF_DEPTH
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // single-wire line
  input  wire logic        uart_in,
  output logic             uart_out,
  output logic             uart_oe,
  // node select pins
  input  wire logic        node_pin_lsb,
  input  wire logic        node_pin_msb,
  // register write port
  output logic             wr_valid,
  input  wire logic        wr_ready,
  output logic [6:0]       wr_addr,
  output logic [31:0]      wr_data,
  // read request and status
  output logic             rd_valid,
  output logic [6:0]       rd_addr,
  output logic [7:0]       dgram_count,
  output logic             link_error
);
  swu_state_t     state;
  swu_state_t     next_state;
  logic [2:0]     byte_idx;
  logic [2:0]     next_byte_idx;
  logic [2:0]     bit_idx;
  logic [2:0]     next_bit_idx;
  logic [CW-1:0]  cyc;
  logic [CW-1:0]  next_cyc;
  logic [CW-1:0]  gap;
  logic [CW-1:0]  next_gap;
  logic [CW-1:0]  target;
  logic [CW-1:0]  next_target;
  logic [7:0]     shreg;
  logic [7:0]     next_shreg;
  logic           line_q;
  logic           fall_seen;
  logic           next_fall_seen;
  logic [BW-1:0]  bit_cur;
  logic [BW-1:0]  next_bit_cur;
  logic [BW-1:0]  bit_good;
  logic [BW-1:0]  next_bit_good;
  logic [7:0]     crc;
  logic [7:0]     next_crc;
  logic           match;
  logic           next_match;
  logic           is_write;
  logic           next_is_write;
  logic [6:0]     reg_addr;
  logic [6:0]     next_reg_addr;
  logic [31:0]    data;
  logic [31:0]    next_data;
  logic [1:0]     node_select;
  logic [7:0]     next_count;
  logic           next_rd_valid;
  logic [6:0]     next_rd_addr;
  logic           next_link_error;
  logic           push_valid;
  logic           buf_ready;
  logic           fall;
  logic [7:0]     rx_byte;
  logic           last_byte;
  logic [CW-1:0]  gap_lim;
  logic [CW-1:0]  idle_lim;
  logic           in_frame;

  // serial crc over one byte, lsb first
  function automatic logic [7:0] crc_byte(input logic [7:0] crc_in, input logic [7:0] b);
    logic [7:0] r;
    r = crc_in;
    for (int j = 0; j < 8; j++)
    begin
      if (r[7] ^ b[j])
      begin
        r = {r[6:0], 1'b0} ^ `SWU_CRC_POLY;
      end
      else
      begin
        r = {r[6:0], 1'b0};
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reply driver is not built: the pin stays released so the pull-up holds it high
  assign uart_out   = 1'b1;
  assign uart_oe    = 1'b0;
  assign push_valid = (state == S_PUSH);
  assign fall       = line_q & ~uart_in;
  // limits scale with the bit time of the last good datagram
  assign gap_lim    = CW'(bit_good) * CW'(`SWU_GAP_BITS);
  assign idle_lim   = CW'(bit_good) * CW'(`SWU_IDLE_BITS);
  assign in_frame   = (byte_idx != '0) || (state == S_SYNC);
  // sync byte keeps its fixed low bits; bit 3 is checked separately
  assign rx_byte    = (byte_idx == '0) ? {shreg[7:3], `SWU_SYNC_LOW3} : shreg;
  // a read request ends after its fourth byte, a write after its eighth
  assign last_byte  = is_write ? (byte_idx == `SWU_WR_LAST) : (byte_idx == `SWU_RD_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // receiver next-state logic
  always_comb
  begin
    next_state      = state;
    next_byte_idx   = byte_idx;
    next_bit_idx    = bit_idx;
    next_cyc        = cyc + 1'b1;
    next_gap        = (gap == '1) ? gap : gap + 1'b1;
    next_target     = target;
    next_shreg      = shreg;
    next_fall_seen  = fall_seen;
    next_bit_cur    = bit_cur;
    next_bit_good   = bit_good;
    next_crc        = crc;
    next_match      = match;
    next_is_write   = is_write;
    next_reg_addr   = reg_addr;
    next_data       = data;
    next_count      = dgram_count;
    next_rd_valid   = 1'b0;
    next_rd_addr    = rd_addr;
    next_link_error = 1'b0;
    case (state)
      S_IDLE:
      begin
        next_cyc = cyc;
        if (fall)
        begin
          next_cyc   = CW'(1);
          next_gap   = CW'(1);
          next_state = S_START;
        end
      end
      S_START:
      begin
        if (uart_in)
        begin
          next_link_error = 1'b1;
        end
        else if (cyc == CW'(`SWU_GLITCH_CYC - 1))
        begin
          if (byte_idx == '0)
          begin
            next_fall_seen = 1'b0;
            next_state     = S_SYNC;
          end
          else
          begin
            next_target  = CW'(bit_cur) + CW'(bit_cur >> 1);
            next_bit_idx = '0;
            next_state   = S_BITS;
          end
        end
      end
      S_SYNC:
      begin
        if (fall)
        begin
          if (fall_seen)
          begin
            // second fall after start closes four bit times
            next_bit_cur = cyc[BW+1:2];
            next_target  = cyc + (cyc >> 3);
            next_bit_idx = `SWU_FIRST_DATA;
            next_state   = S_BITS;
          end
          next_fall_seen = 1'b1;
        end
      end
      S_BITS:
      begin
        if (cyc == target)
        begin
          next_shreg[bit_idx] = uart_in;
          next_target         = target + CW'(bit_cur);
          next_bit_idx        = bit_idx + 1'b1;
          if (bit_idx == 3'h7)
          begin
            next_state = S_STOP;
          end
        end
      end
      S_STOP:
      begin
        if (cyc == target)
        begin
          next_state = S_IDLE;
          if (!uart_in || (byte_idx == '0 && shreg[3]))
          begin
            next_link_error = 1'b1;
          end
          else if (byte_idx >= `SWU_FIRST_DATA && last_byte)
          begin
            next_byte_idx = '0;
            if (rx_byte != crc)
            begin
              next_link_error = 1'b1;
            end
            else
            begin
              next_bit_good = bit_cur;
              if (match && is_write)
              begin
                next_state = S_PUSH;
              end
              else if (match)
              begin
                next_rd_valid = 1'b1;
                next_rd_addr  = reg_addr;
              end
            end
          end
          else
          begin
            next_byte_idx = byte_idx + 1'b1;
            next_crc      = crc_byte((byte_idx == '0) ? `SWU_CRC_INIT : crc, rx_byte);
            case (byte_idx)
              3'h1:    next_match = (rx_byte == {6'h00, node_select});
              3'h2:
              begin
                next_is_write = rx_byte[7];
                next_reg_addr = rx_byte[6:0];
              end
              default: next_data = {data[23:0], rx_byte};
            endcase
          end
        end
      end
      S_PUSH:
      begin
        // waits on the buffer; a full buffer stalls the receiver here
        next_cyc = cyc;
        if (buf_ready)
        begin
          next_count = dgram_count + 1'b1;
          next_state = S_IDLE;
        end
      end
      S_RECOVER:
      begin
        // line must stay high for the whole idle window
        next_cyc = uart_in ? cyc + 1'b1 : '0;
        if (cyc >= idle_lim)
        begin
          next_state = S_IDLE;
        end
      end
      default:
      begin
        next_link_error = 1'b1;
      end
    endcase
    // pause between start bits inside a datagram
    if (state != S_RECOVER && state != S_PUSH && in_frame && gap > gap_lim)
    begin
      next_link_error = 1'b1;
    end
    if (next_link_error)
    begin
      next_state    = S_RECOVER;
      next_byte_idx = '0;
      next_cyc      = '0;
    end
  end

  // receiver registers
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state       <= S_IDLE;
      byte_idx    <= '0;
      bit_idx     <= '0;
      cyc         <= '0;
      gap         <= '0;
      target      <= '0;
      shreg       <= 8'h00;
      line_q      <= 1'b1;
      fall_seen   <= 1'b0;
      bit_cur     <= BW'(BIT_INIT);
      bit_good    <= BW'(BIT_INIT);
      crc         <= `SWU_CRC_INIT;
      match       <= 1'b0;
      is_write    <= 1'b0;
      reg_addr    <= 7'h00;
      data        <= 32'h0000_0000;
      node_select <= 2'h0;
      dgram_count <= `SWU_CNT_INIT;
      rd_valid    <= 1'b0;
      rd_addr     <= 7'h00;
      link_error  <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      byte_idx    <= next_byte_idx;
      bit_idx     <= next_bit_idx;
      cyc         <= next_cyc;
      gap         <= next_gap;
      target      <= next_target;
      shreg       <= next_shreg;
      line_q      <= uart_in;
      fall_seen   <= next_fall_seen;
      bit_cur     <= next_bit_cur;
      bit_good    <= next_bit_good;
      crc         <= next_crc;
      match       <= next_match;
      is_write    <= next_is_write;
      reg_addr    <= next_reg_addr;
      data        <= next_data;
      node_select <= {node_pin_msb, node_pin_lsb};
      dgram_count <= next_count;
      rd_valid    <= next_rd_valid;
      rd_addr     <= next_rd_addr;
      link_error  <= next_link_error;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer between accepted writes and the register port
  swu_buf #(
    .W     (39),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .in_valid  (push_valid),
    .in_ready  (buf_ready),
    .in_data   ({reg_addr, data}),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  ({wr_addr, wr_data})
  );
endmodule

// ### shared/swu_cfg.svh
// constants of the single-wire uart write slave: timing, framing, crc, reset values
// assumes a 250 MHz system clock; included by bare name
`ifndef SWU_CFG_SVH
`define SWU_CFG_SVH
`define SWU_CLK_HZ       250000000
`define SWU_BAUD_MIN     9000
`define SWU_BIT_MAX_CYC  (`SWU_CLK_HZ / `SWU_BAUD_MIN)
`define SWU_GLITCH_CYC   16
`define SWU_GAP_BITS     63
`define SWU_IDLE_BITS    12
`define SWU_SYNC_LOW3    3'h5
`define SWU_CRC_POLY     8'h07
`define SWU_CRC_INIT     8'h00
`define SWU_WR_LAST      3'h7
`define SWU_RD_LAST      3'h3
`define SWU_FIRST_DATA   3'h3
`define SWU_BUF_DEPTH    2
`define SWU_CNT_INIT     8'h00
`endif

// ### shared/swu_pkg.sv
// types of the single-wire uart write slave
// assumes nothing beyond a systemverilog compiler
package swu_pkg;
  typedef enum logic [2:0]
  {
    S_IDLE    = 3'h0,
    S_START   = 3'h1,
    S_SYNC    = 3'h2,
    S_BITS    = 3'h3,
    S_STOP    = 3'h4,
    S_PUSH    = 3'h5,
    S_RECOVER = 3'h6
  } swu_state_t;
endpackage

// ### rtl/swu_buf.sv
// small fifo between the datagram receiver and the register write port
// assumes one clock, asynchronous active-low reset
`timescale 1ns/1ps
module swu_buf #(
  parameter int W     = 39,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  // filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem      [DEPTH];
  logic [W-1:0]  next_mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   fill;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0]   next_fill;
  logic          push;
  logic          pop;

  // pointer step with wrap at depth
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1))
    begin
      return '0;
    end
    return p + 1'b1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // handshake flags from the fill level
  assign in_ready  = (fill != (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // next pointers, level and storage
  always_comb
  begin
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_fill   = fill;
    if (push)
    begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr      = ptr_inc(wr_ptr);
    end
    if (pop)
    begin
      next_rd_ptr = ptr_inc(rd_ptr);
    end
    if (push && !pop)
    begin
      next_fill = fill + 1'b1;
    end
    else if (pop && !push)
    begin
      next_fill = fill - 1'b1;
    end
  end

  // control state with reset
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill   <= next_fill;
    end
  end

  // storage needs no reset
  always_ff @(posedge clk_sys)
  begin
    mem <= next_mem;
  end
endmodule

// ### verification/swu_mst.sv
// partner model: microcontroller uart master on the shared line
// assumes callers run at falling clock edges; the line has a pull-up
`timescale 1ns/1ps
module swu_mst (
  // clock
  input  wire logic clk_sys,
  // shared line, master side
  output logic      line
);
  logic [7:0] q[$];
  int         bt = 32; // bit time in cycles, kept in 16..27777, no abrupt rise
  initial line = 1'b1; // idle high
  ////////////////////////////////////////////////////////////////////////////
  // hold a level for n cycles
  task automatic hold(input logic v, input int n);
    line = v;
    repeat (n) @(negedge clk_sys);
  endtask
  // one byte: start low, bits lsb first, stop high
  task automatic tx(input logic [7:0] b);
    hold(1'b0, bt);
    for (int i = 0; i < 8; i++) hold(b[i], bt);
    hold(1'b1, bt);
  endtask
  // send the queued bytes in order
  task automatic send;
    foreach (q[i]) tx(q[i]);
    q.delete();
  endtask
  // append crc8 (poly 07, init zero, lsb first), optionally corrupted, then send
  task automatic frame(input logic bad);
    logic [7:0] c;
    c = 8'h00;
    foreach (q[i]) for (int j = 0; j < 8; j++) c = {c[6:0], 1'b0} ^ ((c[7] ^ q[i][j]) ? 8'h07 : 8'h00);
    q.push_back(c ^ {7'h00, bad});
    send();
  endtask
  // idle line for n bit times
  task automatic idle(input int n);
    hold(1'b1, n * bt);
  endtask
  // short low pulse of n cycles, then one bit of idle
  task automatic glitch(input int n);
    hold(1'b0, n);
    hold(1'b1, bt);
  endtask
endmodule

// ### verification/swu_slave_props.sv
// checker of the single-wire uart write slave ports
// assumes one clock domain; attached to every swu_slave by bind
`timescale 1ns/1ps
module swu_slave_props (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        reset_n,
  // line
  input wire logic        uart_out,
  input wire logic        uart_oe,
  // write port
  input wire logic        wr_valid,
  input wire logic        wr_ready,
  input wire logic [6:0]  wr_addr,
  input wire logic [31:0] wr_data,
  // status
  input wire logic        rd_valid,
  input wire logic [7:0]  dgram_count,
  input wire logic        link_error
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  // line is never driven, so it stays at its idle high
  AST_OE_OFF: assert property (!uart_oe) else $error("line driven");
  AST_OUT_HIGH: assert property (uart_out) else $error("line output low");
  // a stalled word holds still
  AST_WR_HOLD: assert property (wr_valid && !wr_ready |=>
    wr_valid && $stable(wr_addr) && $stable(wr_data)) else $error("write word changed while stalled");
  // counter only ever steps by one, wrapping
  AST_CNT_STEP: assert property ($changed(dgram_count) |->
    dgram_count == $past(dgram_count) + 8'h01) else $error("count jump");
  // every count step comes with a write word
  AST_CNT_WR: assert property ($changed(dgram_count) |-> ##[0:1] wr_valid) else $error("count without word");
  // read request is a pulse and leaves the counter alone
  AST_RD_PULSE: assert property (rd_valid |=> !rd_valid) else $error("read pulse too long");
  AST_RD_NOCNT: assert property (rd_valid |-> $stable(dgram_count)) else $error("read counted");
  // an error is a pulse and no write is accepted right after it
  AST_ERR_PULSE: assert property (link_error |=> !link_error) else $error("error pulse too long");
  AST_ERR_QUIET: assert property (link_error |-> ##1 $stable(dgram_count) [*8])
    else $error("write accepted after error");
  // main scenarios
  cover property (wr_valid && !wr_ready);
  cover property (rd_valid);
  cover property (link_error);
endmodule
bind swu_slave swu_slave_props chk (.clk_sys(clk_sys), .reset_n(reset_n), .uart_out(uart_out), .uart_oe(uart_oe),
  .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .rd_valid(rd_valid),
  .dgram_count(dgram_count), .link_error(link_error));

// ### verification/testbench.sv
// self-checking testbench of the single-wire uart write slave
// assumes swu_mst drives the line; the slave never drives it
`timescale 1ns/1ps
module testbench;
  logic        clk_sys;
  logic        reset_n;
  logic        node_pin_lsb;
  logic        node_pin_msb;
  logic        wr_ready;
  logic        err;
  logic        rd_hit;
  logic [6:0]  rd_got;
  wire         line;
  wire         uart_in;
  wire         uart_out;
  wire         uart_oe;
  wire         wr_valid;
  wire         rd_valid;
  wire         link_error;
  wire [6:0]   wr_addr;
  wire [6:0]   rd_addr;
  wire [31:0]  wr_data;
  wire [7:0]   dgram_count;
  int          n_mismatch;
  int          n_compared;
  // wire level: slave output only when enabled
  assign uart_in = uart_oe ? uart_out : line;
  swu_mst m (.clk_sys(clk_sys), .line(line));
  swu_slave #(.BIT_INIT(64)) uut (.clk_sys(clk_sys), .reset_n(reset_n), .uart_in(uart_in), .uart_out(uart_out),
    .uart_oe(uart_oe), .node_pin_lsb(node_pin_lsb), .node_pin_msb(node_pin_msb), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .rd_valid(rd_valid), .rd_addr(rd_addr),
    .dgram_count(dgram_count), .link_error(link_error));
  ////////////////////////////////////////////////////////////////////////////
  // clock, sticky pulse catchers, watchdog
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    if (link_error === 1'b1) err <= 1'b1;
    if (rd_valid === 1'b1) rd_hit <= 1'b1;
    if (rd_valid === 1'b1) rd_got <= rd_addr;
  end
  initial
  begin
    #400000;
    n_mismatch++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [1:0] n, input logic [6:0] a, input logic [31:0] d, input logic bad);
    m.q = '{8'h05, {6'h00, n}, {1'b1, a}, d[31:24], d[23:16], d[15:8], d[7:0]};
    m.frame(bad);
  endtask
  // wait bounded for a word and take it in one cycle
  task automatic take(output logic [38:0] w);
    int i;
    i = 0;
    do
    begin
      @(negedge clk_sys);
      i++;
    end while (wr_valid !== 1'b1 && i < 3000);
    w = {wr_addr, wr_data};
    wr_ready = 1'b1;
    @(negedge clk_sys);
    wr_ready = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_write(input logic [1:0] n, input int b, input logic [6:0] a, input logic [31:0] d);
    logic [38:0] w;
    logic [7:0]  c;
    c = dgram_count;
    {node_pin_msb, node_pin_lsb} = n;
    m.bt = b;
    wr(n, a, d, 1'b0);
    take(w);
    chk(w === {a, d}, "write word");
    chk(dgram_count === c + 8'h01, "write count");
    m.idle(16);
  endtask
  task automatic t_other;
    logic [7:0] c;
    c = dgram_count;
    err = 1'b0;
    wr(2'h2, 7'h11, 32'h0000_FFFF, 1'b0);
    repeat (20) @(negedge clk_sys);
    chk(wr_valid === 1'b0 && dgram_count === c && err === 1'b0, "other node acted on");
    m.idle(16);
  endtask
  task automatic t_read;
    logic [7:0] c;
    c = dgram_count;
    rd_hit = 1'b0;
    m.q = '{8'h05, 8'h01, 8'h15};
    m.frame(1'b0);
    repeat (20) @(negedge clk_sys);
    chk(rd_hit === 1'b1 && rd_got === 7'h15, "read request");
    chk(dgram_count === c, "read counted");
    m.idle(16);
  endtask
  // k: 0 bad crc, 1 glitch, 2 gap inside a datagram
  task automatic t_bad(input int k);
    logic [7:0] c;
    c = dgram_count;
    err = 1'b0;
    if (k == 0) wr(2'h1, 7'h22, 32'hA5A5_0F0F, 1'b1);
    else if (k == 1) m.glitch(8);
    else
    begin
      m.q = '{8'h05, 8'h01};
      m.send();
      m.idle(70);
    end
    repeat (20) @(negedge clk_sys);
    chk(err === 1'b1, "no error flagged");
    chk(dgram_count === c && wr_valid === 1'b0, "bad datagram acted on");
    m.idle(16);
  endtask
  task automatic t_stall;
    logic [38:0] w;
    logic [7:0]  c;
    int          i;
    c = dgram_count;
    for (i = 0; i < 3; i++)
    begin
      wr(2'h1, 7'h30 + i[6:0], 32'hC0DE_0000 + i, 1'b0);
      m.idle(16);
    end
    chk(dgram_count === c + 8'h02 && wr_valid === 1'b1 && wr_addr === 7'h30, "full buffer");
    for (i = 0; i < 3; i++)
    begin
      take(w);
      chk(w === {7'h30 + i[6:0], 32'hC0DE_0000 + i}, "word order");
    end
    chk(dgram_count === c + 8'h03, "drained count");
  endtask
  // reset in mid-run with a word waiting, then a fresh write at a 20-cycle bit time
  task automatic t_reset;
    wr(2'h1, 7'h05, 32'h5A5A_C3C3, 1'b0);
    repeat (4) @(negedge clk_sys);
    chk(wr_valid === 1'b1 && wr_addr === 7'h05, "word before reset");
    reset_n = 1'b0;
    repeat (10) @(negedge clk_sys);
    chk(wr_valid === 1'b0 && dgram_count === 8'h00 && link_error === 1'b0 && rd_valid === 1'b0, "mid-run reset");
    reset_n = 1'b1;
    m.idle(2);
    t_write(2'h1, 20, 7'h05, 32'h5A5A_C3C3);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  task automatic summarize;
    if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    reset_n = 1'b0;
    wr_ready = 1'b0;
    node_pin_lsb = 1'b0;
    node_pin_msb = 1'b1;
    err = 1'b0;
    rd_hit = 1'b0;
    rd_got = 7'h00;
    repeat (10) @(negedge clk_sys);
    reset_n = 1'b1;
    chk(dgram_count === 8'h00 && wr_valid === 1'b0 && uart_oe === 1'b0, "reset state");
    m.idle(2);
    t_write(2'h2, 32, 7'h10, 32'h1234_5678);
    t_write(2'h1, 20, 7'h7F, 32'h89AB_CDEF);
    t_other();
    t_read();
    t_bad(0);
    t_bad(1);
    t_bad(2);
    t_stall();
    t_reset();
    summarize();
  end
endmodule
